// *** ste_alu.sv ***
// combinational datapath: results, skip decisions and write enables
`timescale 1ns/1ns
`include "ste_defs.svh"
module ste_alu
  import ste_pkg::*;
(
  // operands in, results out
  ste_alu_if.alu a
);

  // ****************************************
  // zero test on a byte
  // ****************************************
  function automatic logic is_null(input logic [`STE_BYTE_W-1:0] v);
    is_null = (v == `STE_BYTE_ZERO);
  endfunction : is_null

  // ****************************************
  // result selection per instruction
  // ****************************************
  always_comb
  begin
    a.result   = `STE_BYTE_ZERO;
    a.skip     = 1'b0;
    a.wr_wreg  = 1'b0;
    a.wr_mem   = 1'b0;
    a.wr_flag  = 1'b0;
    a.table_rd = 1'b0;
    case (a.op)
      ste_op_nibble_swap_to_working:
      begin
        a.result  = {a.mem_byte[`STE_NIB_W-1:0],
                     a.mem_byte[`STE_BYTE_W-1:`STE_NIB_W]};
        a.wr_wreg = 1'b1;
      end
      ste_op_skip_on_null:
      begin
        a.skip = is_null(a.mem_byte);
      end
      ste_op_copy_and_skip_on_null:
      begin
        a.result  = a.mem_byte;
        a.wr_wreg = 1'b1;
        a.skip    = is_null(a.mem_byte);
      end
      ste_op_skip_on_null_bit:
      begin
        a.skip = ~a.mem_byte[a.bit_sel];
      end
      ste_op_table_read_current_page,
      ste_op_table_read_last_page:
      begin
        a.table_rd = 1'b1;
      end
      ste_op_xor_to_working:
      begin
        a.result  = a.wreg ^ a.mem_byte;
        a.wr_wreg = 1'b1;
        a.wr_flag = 1'b1;
      end
      ste_op_exclusive_or_to_memory:
      begin
        a.result  = a.wreg ^ a.mem_byte;
        a.wr_mem  = 1'b1;
        a.wr_flag = 1'b1;
      end
      ste_op_xor_immediate:
      begin
        a.result  = a.wreg ^ a.imm;
        a.wr_wreg = 1'b1;
        a.wr_flag = 1'b1;
      end
      default:
      begin
        a.result = `STE_BYTE_ZERO;
      end
    endcase
  end

  // null flag of the exclusive-or result
  assign a.null_res = is_null(a.result);

endmodule : ste_alu

// *** ste_alu_if.sv ***
// operands and results between the sequencer and the datapath
`timescale 1ns/1ns
`include "ste_defs.svh"
interface ste_alu_if;
  import ste_pkg::*;
  ste_op_e                  op;
  logic [`STE_BYTE_W-1:0]   wreg;
  logic [`STE_BYTE_W-1:0]   mem_byte;
  logic [`STE_BYTE_W-1:0]   imm;
  logic [`STE_BITSEL_W-1:0] bit_sel;
  logic [`STE_BYTE_W-1:0]   result;
  logic                     null_res;
  logic                     skip;
  logic                     wr_wreg;
  logic                     wr_mem;
  logic                     wr_flag;
  logic                     table_rd;

  modport seq (output op, wreg, mem_byte, imm, bit_sel,
               input  result, null_res, skip, wr_wreg, wr_mem, wr_flag, table_rd);
  modport alu (input  op, wreg, mem_byte, imm, bit_sel,
               output result, null_res, skip, wr_wreg, wr_mem, wr_flag, table_rd);
endinterface : ste_alu_if

// *** ste_chk.sv ***
// concurrent checks on the skip, table read and exclusive-or block
`timescale 1ns/1ns
`include "ste_defs.svh"
module ste_chk
  import ste_pkg::*;
#(
  parameter int PM_AW = 12,
  parameter int PM_DW = 15,
  parameter int DM_AW = 8
)
(
  // clock and reset
  input wire logic                     mclk,
  input wire logic                     sys_rst,
  // decoder side
  input wire logic                     instr_valid,
  input wire ste_op_e                  instr_op,
  input wire logic [DM_AW-1:0]         instr_addr,
  input wire logic [2:0]               instr_bit,
  input wire logic [7:0]               instr_imm,
  input wire logic                     busy,
  input wire logic                     flush,
  // memories
  input wire logic [7:0]               mem_rdata,
  input wire logic                     mem_we,
  input wire logic [DM_AW-1:0]         mem_waddr,
  input wire logic [7:0]               mem_wdata,
  input wire logic [PM_AW-9:0]         cur_page,
  input wire logic [7:0]               table_pointer,
  input wire logic [PM_DW-1:0]         rom_data,
  input wire logic                     rom_re,
  input wire logic [PM_AW-1:0]         rom_addr,
  // state
  input wire logic [7:0]               working_register,
  input wire logic [PM_DW-9:0]         table_high_latch,
  input wire logic                     null_flag
);
  logic       take;
  logic [7:0] xr_q;
  logic [7:0] sw_q;
  logic       bz_q;

  // expected results one cycle on
  assign take = instr_valid && !busy;
  always_ff @(posedge mclk)
  begin
    xr_q <= working_register ^ ((instr_op == ste_op_xor_immediate) ? instr_imm : mem_rdata);
    sw_q <= {mem_rdata[3:0], mem_rdata[7:4]};
    bz_q <= !mem_rdata[instr_bit];
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  skip_taken_a:
    assert property (take && instr_op == ste_op_skip_on_null && mem_rdata == 8'h00 |=> flush && busy)
      else $error("zero byte skip missing");
  skip_not_a:
    assert property (take && instr_op == ste_op_skip_on_null && mem_rdata != 8'h00 |=> !flush && !busy)
      else $error("nonzero byte skipped");
  bit_skip_a:
    assert property (take && instr_op == ste_op_skip_on_null_bit |=> flush == bz_q)
      else $error("bit skip wrong");
  copy_skip_a:
    assert property (take && instr_op == ste_op_copy_and_skip_on_null |=>
      working_register == $past(mem_rdata) && flush == (working_register == 8'h00))
      else $error("copy skip wrong");
  dummy_quiet_a:
    assert property (flush |=> !flush && !busy && !mem_we && $stable(working_register)
      && $stable(null_flag) && $stable(table_high_latch)) else $error("dummy cycle not idle");
  xor_wreg_a:
    assert property (take && instr_op inside {ste_op_xor_to_working, ste_op_xor_immediate} |=>
      working_register == xr_q && null_flag == (xr_q == 8'h00) && !mem_we)
      else $error("xor to register wrong");
  xor_mem_a:
    assert property (take && instr_op == ste_op_exclusive_or_to_memory |=> mem_we
      && mem_wdata == xr_q && mem_waddr == $past(instr_addr)
      && null_flag == (xr_q == 8'h00) && $stable(working_register)) else $error("xor to memory wrong");
  swap_a:
    assert property (take && instr_op == ste_op_nibble_swap_to_working |=>
      working_register == sw_q && !mem_we) else $error("nibble swap wrong");
  tab_cur_a:
    assert property (take && instr_op == ste_op_table_read_current_page |=> rom_re && busy
      && rom_addr == {$past(cur_page), $past(table_pointer)} ##2 mem_we && !busy
      && {table_high_latch, mem_wdata} == $past(rom_data)) else $error("current page read wrong");
  tab_last_a:
    assert property (take && instr_op == ste_op_table_read_last_page |=> rom_re
      && rom_addr == {{(PM_AW-8){1'b1}}, $past(table_pointer)}) else $error("last page address wrong");
  flag_keep_a:
    assert property (take && instr_op inside {ste_op_skip_on_null, ste_op_skip_on_null_bit,
      ste_op_copy_and_skip_on_null, ste_op_table_read_current_page, ste_op_table_read_last_page}
      |=> $stable(null_flag)) else $error("null flag moved");
endmodule : ste_chk

bind ste_exec ste_chk #(.PM_AW(PM_AW), .PM_DW(PM_DW), .DM_AW(DM_AW)) i_ste_chk (
  .mclk             (mclk),
  .sys_rst          (sys_rst),
  .instr_valid      (instr_valid),
  .instr_op         (instr_op),
  .instr_addr       (instr_addr),
  .instr_bit        (instr_bit),
  .instr_imm        (instr_imm),
  .busy             (busy),
  .flush            (flush),
  .mem_rdata        (mem_rdata),
  .mem_we           (mem_we),
  .mem_waddr        (mem_waddr),
  .mem_wdata        (mem_wdata),
  .cur_page         (cur_page),
  .table_pointer    (table_pointer),
  .rom_data         (rom_data),
  .rom_re           (rom_re),
  .rom_addr         (rom_addr),
  .working_register (working_register),
  .table_high_latch (table_high_latch),
  .null_flag        (null_flag)
);

// *** ste_defs.svh ***
// constants for the skip, table read and exclusive-or execution block
`ifndef STE_DEFS_SVH
`define STE_DEFS_SVH

// ****************************************
// data widths and fields
// ****************************************
`define STE_BYTE_W     8
`define STE_NIB_W      4
`define STE_BITSEL_W   3
`define STE_PAGE_W     8
`define STE_BYTE_ZERO  8'h00

// ****************************************
// default memory geometry
// ****************************************
`define STE_PM_AW_DEF  12
`define STE_PM_DW_DEF  15
`define STE_DM_AW_DEF  8

`endif

// *** ste_exec.sv ***
// sequencer for skip, table read and exclusive-or instructions
`timescale 1ns/1ns
`include "ste_defs.svh"

// How it works
// - The nibble swap puts the memory byte with its halves exchanged into the working register.
// - Skip on null flushes the prefetched instruction with one dummy cycle when the byte is zero.
// - Copy and skip on null loads the byte into the working register and skips when it is zero.
// - The bit test skip flushes and adds a dummy cycle when the selected bit is zero.
// - The current page table read writes the word's low byte to memory and its high part to the latch.
// - The last page table read does the same from the final page of program memory.
// - XOR with memory into the working register updates only the null flag.
// - XOR into memory stores the result in the byte and updates only the null flag.
// - XOR with the immediate into the working register updates only the null flag.
module ste_exec
  import ste_pkg::*;
#(
  parameter int PM_AW = `STE_PM_AW_DEF,
  parameter int PM_DW = `STE_PM_DW_DEF,
  parameter int DM_AW = `STE_DM_AW_DEF
)
(
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  // instruction from the decoder
  input  wire logic                              instr_valid,
  input  wire ste_op_e                           instr_op,
  input  wire logic [DM_AW-1:0]                  instr_addr,
  input  wire logic [`STE_BITSEL_W-1:0]          instr_bit,
  input  wire logic [`STE_BYTE_W-1:0]            instr_imm,
  output logic                                   busy,
  output logic                                   flush,
  // data memory
  input  wire logic [`STE_BYTE_W-1:0]            mem_rdata,
  output logic                                   mem_we,
  output logic [DM_AW-1:0]                       mem_waddr,
  output logic [`STE_BYTE_W-1:0]                 mem_wdata,
  // program memory for table reads
  input  wire logic [PM_AW-`STE_PAGE_W-1:0]      cur_page,
  input  wire logic [`STE_PAGE_W-1:0]            table_pointer,
  input  wire logic [PM_DW-1:0]                  rom_data,
  output logic                                   rom_re,
  output logic [PM_AW-1:0]                       rom_addr,
  // architectural state
  output logic [`STE_BYTE_W-1:0]                 working_register,
  output logic [PM_DW-`STE_BYTE_W-1:0]           table_high_latch,
  output logic                                   null_flag
);

  // ****************************************
  // parameter checks
  // ****************************************
  if (PM_AW <= `STE_PAGE_W)
  begin : g_chk_aw
    $error("program address must be wider than one page");
  end
  if (PM_DW <= `STE_BYTE_W)
  begin : g_chk_dw
    $error("program word must be wider than one byte");
  end
  // an address must select at least one data memory byte
  if (DM_AW < 1)
  begin : g_chk_dm
    $error("data address must have at least one bit");
  end

  // width of the page number and of the high part of a program word
  localparam int PG_W = PM_AW - `STE_PAGE_W;
  localparam int HI_W = PM_DW - `STE_BYTE_W;

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    ste_state_e                 st;
    logic                       busy;
    logic                       flush;
    logic                       mem_we;
    logic [DM_AW-1:0]           mem_waddr;
    logic [`STE_BYTE_W-1:0]     mem_wdata;
    logic                       rom_re;
    logic [PM_AW-1:0]           rom_addr;
    logic [`STE_BYTE_W-1:0]     wreg;
    logic [HI_W-1:0]            tbl_hi;
    logic                       znull;
  } ste_state_s;

  // current and next copy of the whole state
  ste_state_s s_q;
  ste_state_s s_d;

  // ****************************************
  // datapath
  // ****************************************
  ste_alu_if alu_if ();

  ste_alu u_alu (
    .a (alu_if.alu)
  );

  // operands go straight from the decoder, the memory read port and the working register
  assign alu_if.op       = instr_op;
  assign alu_if.wreg     = s_q.wreg;
  assign alu_if.mem_byte = mem_rdata;
  assign alu_if.imm      = instr_imm;
  assign alu_if.bit_sel  = instr_bit;

  // taken only in the run state; while busy the decoder holds its instruction
  logic take;
  assign take = instr_valid && (s_q.st == ste_st_run);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.flush  = 1'b0;                 // one-cycle pulses
    s_d.mem_we = 1'b0;
    s_d.rom_re = 1'b0;
    case (s_q.st)
      ste_st_run:
      begin
        s_d.busy = 1'b0;
        if (take)
        begin
          if (alu_if.wr_wreg)
          begin
            s_d.wreg = alu_if.result;
          end
          if (alu_if.wr_mem)
          begin
            s_d.mem_we    = 1'b1;
            s_d.mem_waddr = instr_addr;
            s_d.mem_wdata = alu_if.result;
          end
          if (alu_if.wr_flag)
          begin
            s_d.znull = alu_if.null_res;
          end
          if (alu_if.skip)
          begin
            s_d.st    = ste_st_dummy;
            s_d.flush = 1'b1;
            s_d.busy  = 1'b1;
          end
          else if (alu_if.table_rd)
          begin
            s_d.st        = ste_st_tab_addr;
            s_d.busy      = 1'b1;
            s_d.rom_re    = 1'b1;
            s_d.mem_waddr = instr_addr;
            if (instr_op == ste_op_table_read_last_page)
            begin
              s_d.rom_addr = {{PG_W{1'b1}}, table_pointer};
            end
            else
            begin
              s_d.rom_addr = {cur_page, table_pointer};
            end
          end
        end
      end
      ste_st_dummy:
      begin
        s_d.st   = ste_st_run;
        s_d.busy = 1'b0;
      end
      ste_st_tab_addr:
      begin
        s_d.st = ste_st_tab_data;      // memory answers one cycle after rom_re
      end
      ste_st_tab_data:
      begin
        s_d.st        = ste_st_run;
        s_d.busy      = 1'b0;
        s_d.mem_we    = 1'b1;
        s_d.mem_wdata = rom_data[`STE_BYTE_W-1:0];
        s_d.tbl_hi    = rom_data[PM_DW-1:`STE_BYTE_W];
      end
      default:
      begin
        s_d.st   = ste_st_run;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output comes straight from the state record
  assign busy             = s_q.busy;
  assign flush            = s_q.flush;
  assign mem_we           = s_q.mem_we;
  assign mem_waddr        = s_q.mem_waddr;
  assign mem_wdata        = s_q.mem_wdata;
  assign rom_re           = s_q.rom_re;
  assign rom_addr         = s_q.rom_addr;
  assign working_register = s_q.wreg;
  assign table_high_latch = s_q.tbl_hi;
  assign null_flag        = s_q.znull;

endmodule : ste_exec

// *** ste_pkg.sv ***
// types shared by the execution block and its datapath
package ste_pkg;

  // ****************************************
  // instruction selects from the decoder
  // ****************************************
  typedef enum logic [3:0] {
    ste_op_nop,
    ste_op_nibble_swap_to_working,
    ste_op_skip_on_null,
    ste_op_copy_and_skip_on_null,
    ste_op_skip_on_null_bit,
    ste_op_table_read_current_page,
    ste_op_table_read_last_page,
    ste_op_xor_to_working,
    ste_op_exclusive_or_to_memory,
    ste_op_xor_immediate
  } ste_op_e;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ste_st_run,
    ste_st_dummy,
    ste_st_tab_addr,
    ste_st_tab_data
  } ste_state_e;

endpackage : ste_pkg

// *** tb_top.sv ***
// self-checking bench for the skip, table read and exclusive-or block
`timescale 1ns/1ns
module tb_top
  import ste_pkg::*;
;
  logic        mclk, sys_rst, instr_valid, busy, flush, mem_we, rom_re, null_flag;
  ste_op_e     instr_op;
  logic [7:0]  instr_addr, instr_imm, mem_rdata, mem_waddr, mem_wdata, table_pointer;
  logic [7:0]  working_register;
  logic [2:0]  instr_bit;
  logic [3:0]  cur_page;
  logic [14:0] rom_data;
  logic [11:0] rom_addr;
  logic [6:0]  table_high_latch;
  int          fails = 0, checks_done = 0, cyc = 0;

  ste_exec i_ste_exec (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .instr_valid      (instr_valid),
    .instr_op         (instr_op),
    .instr_addr       (instr_addr),
    .instr_bit        (instr_bit),
    .instr_imm        (instr_imm),
    .busy             (busy),
    .flush            (flush),
    .mem_rdata        (mem_rdata),
    .mem_we           (mem_we),
    .mem_waddr        (mem_waddr),
    .mem_wdata        (mem_wdata),
    .cur_page         (cur_page),
    .table_pointer    (table_pointer),
    .rom_data         (rom_data),
    .rom_re           (rom_re),
    .rom_addr         (rom_addr),
    .working_register (working_register),
    .table_high_latch (table_high_latch),
    .null_flag        (null_flag)
  );

  // clock and cycle ceiling
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // one instruction, effects settled on return except for a table read, which is still busy with rom_re high
  task automatic issue(input ste_op_e op, input logic [7:0] rd, input logic [2:0] b,
                       input logic [7:0] imm);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_op    <= op;
    instr_addr  <= rd ^ 8'h3C;
    mem_rdata   <= rd;
    instr_bit   <= b;
    instr_imm   <= imm;
    @(posedge mclk);
    instr_valid <= 1'b0;
    mem_rdata   <= ~rd;
    #1;
  endtask : issue

  task automatic t_xor();
    issue(ste_op_copy_and_skip_on_null, 8'h5A, 3'h0, 8'h00);
    chk({flush, working_register}, 9'h05A);
    issue(ste_op_xor_to_working, 8'h5A, 3'h0, 8'h00);
    chk({null_flag, working_register}, 9'h100);
    issue(ste_op_xor_immediate, 8'h00, 3'h0, 8'hC3);
    chk({null_flag, working_register}, 9'h0C3);
    issue(ste_op_exclusive_or_to_memory, 8'hC3, 3'h0, 8'h00);
    chk({mem_we, null_flag, mem_waddr, mem_wdata, working_register}, {2'h3, 24'hFF00C3});
  endtask : t_xor

  // skip outcome, then the dummy cycle with the flushed instruction still offered
  task automatic sk(input ste_op_e op, input logic [7:0] rd, input logic [2:0] b,
                    input logic f, input logic [7:0] w);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_op    <= op;
    instr_addr  <= rd ^ 8'h3C;
    mem_rdata   <= rd;
    instr_bit   <= b;
    instr_imm   <= 8'h00;
    @(posedge mclk);
    instr_valid <= f;
    instr_op    <= ste_op_xor_immediate;
    instr_imm   <= 8'hFF;
    mem_rdata   <= ~rd;
    #1;
    chk({flush, busy, null_flag, working_register}, {f, f, 1'b1, w});
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    chk({flush, busy, mem_we, null_flag, working_register}, {3'h0, 1'b1, w});
  endtask : sk

  task automatic tab(input ste_op_e op, input logic [11:0] a);
    @(posedge mclk);
    cur_page      <= 4'h3;
    table_pointer <= 8'h7C;
    issue(op, 8'h11, 3'h0, 8'h00);
    chk({rom_re, busy, rom_addr}, {2'h3, a});
    @(posedge mclk);
    rom_data      <= 15'h4ABC;
    cur_page      <= 4'hC;
    table_pointer <= 8'h83;
    @(posedge mclk);
    rom_data      <= 15'h3543;
    #1;
    chk({mem_we, busy, mem_waddr, mem_wdata, table_high_latch}, {2'h2, 16'h2DBC, 7'h4A});
  endtask : tab

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    instr_op = ste_op_nop;
    {instr_addr, instr_imm, mem_rdata, instr_bit, cur_page, table_pointer, rom_data} = '0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk({busy, flush, mem_we, rom_re, null_flag, table_high_latch, working_register}, 32'h0);
    t_xor();
    sk(ste_op_skip_on_null, 8'h00, 3'h0, 1'b1, 8'hC3);
    sk(ste_op_skip_on_null, 8'h80, 3'h0, 1'b0, 8'hC3);
    sk(ste_op_skip_on_null_bit, 8'hF7, 3'h3, 1'b1, 8'hC3);
    sk(ste_op_skip_on_null_bit, 8'hF7, 3'h7, 1'b0, 8'hC3);
    sk(ste_op_copy_and_skip_on_null, 8'h00, 3'h0, 1'b1, 8'h00);
    issue(ste_op_nibble_swap_to_working, 8'hA5, 3'h0, 8'h00);
    chk({mem_we, working_register}, 9'h05A);
    issue(ste_op_nop, 8'h00, 3'h0, 8'hFF);
    chk({mem_we, flush, busy, null_flag, working_register}, {4'h1, 8'h5A});
    tab(ste_op_table_read_current_page, 12'h37C);
    tab(ste_op_table_read_last_page, 12'hF7C);
    conclude();
  end
endmodule : tb_top
